//--- ksd_top.sv
// Keyboard scanner and pin-event interrupt block with Wishbone slave
//
// The implementer's own choices: the address map and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module ksd_top #(
    parameter int NUM_INPUTS = ksd_pkg::NUM_SCAN,
    parameter int TICK_DIV   = ksd_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                       CLOCK,
    input  wire logic                       RESET_N,
    // Wishbone slave
    input  wire logic                       WB_CYC_I,
    input  wire logic                       WB_STB_I,
    input  wire logic                       WB_WE_I,
    input  wire logic [7:0]                 WB_ADR_I,
    input  wire logic [3:0]                 WB_SEL_I,
    input  wire logic [31:0]                WB_DAT_I,
    output logic      [31:0]                WB_DAT_O,
    output logic                            WB_ACK_O,
    // Port pins
    input  wire logic [NUM_INPUTS-1:0]      PORT_IN,
    // Interrupts
    output logic                            KEYBOARD_INTERRUPT,
    output logic      [ksd_pkg::NUM_PEV-1:0] PIN_EVENT_INTERRUPT_N,
    output logic                            IRQ
);
    import ksd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [NUM_SCAN-1:0] pin_s1_r;
    logic [NUM_SCAN-1:0] pin_s2_r;

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            // Pins idle high through pull-ups, no false edge
            pin_s1_r <= '1;
            pin_s2_r <= '1;
        end else begin
            pin_s1_r <= NUM_SCAN'(PORT_IN);
            pin_s2_r <= pin_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond tick

    // Shared 1 ms enable for scanner and generators
    logic tick;

    ksd_tick #(.DIV(TICK_DIV)) u_tick (
        .clk   (CLOCK),
        .rst_n (RESET_N),
        .tick  (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [DEB_W-1:0]         repeat_r;
    logic                     scan_active_polarity_r;
    logic                     release_report_enable_r;
    logic [NUM_SCAN-1:0]      scan_input_enable_r;
    logic [DEB_W-1:0]         debounce_time_ms_r;
    logic                     scan_debounce_on_r;
    logic [NUM_PEV-1:0]       pev_deb_on_r;
    logic [NUM_PEV-1:0]       pev_polarity_r;
    logic [NUM_PEV-1:0]       pev_edge_r;
    logic [NUM_PEV*SEL_W-1:0] pev_sel_r;
    logic [ST_W-1:0]          irq_status_r;
    logic [ST_W-1:0]          irq_mask_r;
    logic [NUM_PEV-1:0]       pev_clear;
    logic [NUM_PEV-1:0]       pev_flag;
    logic [NUM_PEV-1:0]       pev_pulse;
    logic                     kbd_pulse_r;
    logic                     bus_req;
    logic                     wr_en;
    logic                     rd_en;
    logic [31:0]              rd_nxt;

    // Ack high masks the request, one access per ack
    assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr_en   = bus_req && WB_WE_I;
    assign rd_en   = bus_req && !WB_WE_I;

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            repeat_r                <= '0;
            scan_active_polarity_r  <= 1'b0;
            release_report_enable_r <= 1'b0;
            scan_input_enable_r     <= '0;
            debounce_time_ms_r      <= '0;
            scan_debounce_on_r      <= 1'b0;
            pev_deb_on_r            <= '0;
            pev_polarity_r          <= '0;
            pev_edge_r              <= '0;
            pev_sel_r               <= '0;
            irq_mask_r              <= '0;
        end else if (wr_en) begin
            // Lanes with select low keep their value
            case (WB_ADR_I)
                OFF_SCAN_SETUP: begin
                    if (WB_SEL_I[0]) repeat_r <= WB_DAT_I[SS_REPEAT_LSB +: DEB_W];
                    if (WB_SEL_I[1]) begin
                        scan_active_polarity_r  <= WB_DAT_I[SS_POL_BIT];
                        release_report_enable_r <= WB_DAT_I[SS_REL_BIT];
                    end
                end
                OFF_SCAN_EN: begin
                    for (int b = 0; b < 4; b++) begin
                        if (WB_SEL_I[b]) scan_input_enable_r[b*8 +: 8] <= WB_DAT_I[b*8 +: 8];
                    end
                end
                OFF_DEBOUNCE: begin
                    if (WB_SEL_I[0]) debounce_time_ms_r <= WB_DAT_I[DB_VALUE_LSB +: DEB_W];
                    if (WB_SEL_I[1]) begin
                        scan_debounce_on_r <= WB_DAT_I[DB_SCAN_ON_BIT];
                        pev_deb_on_r       <= WB_DAT_I[DB_PEV_ON_LSB +: NUM_PEV];
                    end
                end
                OFF_PEV_CTRL: begin
                    if (WB_SEL_I[0]) pev_polarity_r <= WB_DAT_I[PC_POL_LSB +: NUM_PEV];
                    if (WB_SEL_I[1]) pev_edge_r     <= WB_DAT_I[PC_EDGE_LSB +: NUM_PEV];
                end
                OFF_PEV_SEL: begin
                    if (&WB_SEL_I) pev_sel_r <= WB_DAT_I[NUM_PEV*SEL_W-1:0];
                end
                OFF_IRQ_MASK: begin
                    if (WB_SEL_I[0]) irq_mask_r <= WB_DAT_I[ST_W-1:0];
                end
                default: ;
            endcase
        end
    end

    // Write of ones to the clear register releases pin-event flags
    assign pev_clear = (wr_en && WB_ADR_I == OFF_PEV_CLEAR && WB_SEL_I[0])
                       ? WB_DAT_I[NUM_PEV-1:0] : '0;

    ////////////////////////////////////////////////////////////////////////////
    // Keyboard scanner

    logic [NUM_SCAN-1:0] scan_act;
    logic [NUM_SCAN-1:0] scan_act_d_r;
    logic                key_hit;
    logic                key_fall;
    ksd_state_t          kst_r;
    logic [DEB_W-1:0]    ktmr_r;
    logic                krel_r;

    // Active level low at polarity 0, only enabled inputs
    assign scan_act = (pin_s2_r ^ {NUM_SCAN{~scan_active_polarity_r}})
                      & scan_input_enable_r;
    assign key_hit  = |scan_act;
    // Any newly active enabled input starts a press in KSD_IDLE
    assign key_fall = |(scan_act & ~scan_act_d_r);

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            scan_act_d_r <= '1;
        end else begin
            scan_act_d_r <= scan_act;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            kst_r       <= KSD_IDLE;
            ktmr_r      <= '0;
            krel_r      <= 1'b0;
            kbd_pulse_r <= 1'b0;
        end else begin
            kbd_pulse_r <= 1'b0;
            // Release debounce reuses DEBOUNCE with krel_r set
            case (kst_r)
                KSD_IDLE: begin
                    if (key_fall) begin
                        ktmr_r <= debounce_time_ms_r;
                        krel_r <= 1'b0;
                        kst_r  <= KSD_DEBOUNCE;
                    end
                end
                KSD_DEBOUNCE: begin
                    if (!key_hit && !krel_r) begin
                        kst_r <= KSD_IDLE;
                    end else if (key_hit && krel_r) begin
                        kst_r <= KSD_IDLE;
                    end else if (!scan_debounce_on_r || ktmr_r == '0) begin
                        kbd_pulse_r <= 1'b1;
                        if (krel_r) begin
                            kst_r <= KSD_IDLE;
                        end else begin
                            ktmr_r <= repeat_r;
                            kst_r  <= KSD_ACTIVE;
                        end
                    end else if (tick) begin
                        ktmr_r <= ktmr_r - 1'b1;
                    end
                end
                KSD_ACTIVE: begin
                    if (!key_hit) begin
                        if (release_report_enable_r) begin
                            ktmr_r <= debounce_time_ms_r;
                            krel_r <= 1'b1;
                            kst_r  <= KSD_DEBOUNCE;
                        end else begin
                            kst_r <= KSD_IDLE;
                        end
                    end else if (repeat_r != '0) begin
                        // Repeat timer runs only while held
                        if (ktmr_r == '0) begin
                            kbd_pulse_r <= 1'b1;
                            ktmr_r      <= repeat_r;
                        end else if (tick) begin
                            ktmr_r <= ktmr_r - 1'b1;
                        end
                    end
                end
                default: kst_r <= KSD_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin-event generators

    for (genvar g = 0; g < NUM_PEV; g++) begin : g_pev
        ksd_pev_cfg_t cfg;
        // Shared debounce time, per-generator enables
        assign cfg = '{
            debounce_time_ms: debounce_time_ms_r,
            deb_on:    pev_deb_on_r[g],
            polarity:  pev_polarity_r[g],
            edge_mode: pev_edge_r[g]
        };

        ksd_pin_event u_pev (
            .clk         (CLOCK),
            .rst_n       (RESET_N),
            .tick        (tick),
            .level       (ksd_pick(pin_s2_r, pev_sel_r[g*SEL_W +: SEL_W])),
            .cfg         (cfg),
            .clear       (pev_clear[g]),
            .flag        (pev_flag[g]),
            .event_pulse (pev_pulse[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, read-to-clear, set wins

    // A new event beats a read in the same cycle
    logic status_rd;
    assign status_rd = rd_en && WB_ADR_I == OFF_IRQ_STATUS;

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_status_r <= '0;
        end else begin
            irq_status_r <= (status_rd ? '0 : irq_status_r) | {pev_pulse, kbd_pulse_r};
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            IRQ                   <= 1'b0;
            KEYBOARD_INTERRUPT    <= 1'b0;
            PIN_EVENT_INTERRUPT_N <= '1;
        end else begin
            // One cycle behind status, kbd_pulse_r and flags
            IRQ                   <= |(irq_status_r & irq_mask_r);
            KEYBOARD_INTERRUPT    <= kbd_pulse_r;
            PIN_EVENT_INTERRUPT_N <= ~pev_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux and acknowledge

    // Unmapped and write-only offsets read zero
    always_comb begin
        rd_nxt = RST_ZERO;
        case (WB_ADR_I)
            OFF_SCAN_SETUP: begin
                rd_nxt[SS_REPEAT_LSB +: DEB_W] = repeat_r;
                rd_nxt[SS_POL_BIT]             = scan_active_polarity_r;
                rd_nxt[SS_REL_BIT]             = release_report_enable_r;
            end
            OFF_SCAN_EN:    rd_nxt = scan_input_enable_r;
            OFF_DEBOUNCE: begin
                rd_nxt[DB_VALUE_LSB +: DEB_W]    = debounce_time_ms_r;
                rd_nxt[DB_SCAN_ON_BIT]           = scan_debounce_on_r;
                rd_nxt[DB_PEV_ON_LSB +: NUM_PEV] = pev_deb_on_r;
            end
            OFF_PEV_CTRL: begin
                rd_nxt[PC_POL_LSB +: NUM_PEV]  = pev_polarity_r;
                rd_nxt[PC_EDGE_LSB +: NUM_PEV] = pev_edge_r;
            end
            OFF_PEV_SEL:    rd_nxt[NUM_PEV*SEL_W-1:0] = pev_sel_r;
            OFF_PEV_FLAGS:  rd_nxt[NUM_PEV-1:0]       = pev_flag;
            OFF_IRQ_STATUS: rd_nxt[ST_W-1:0]          = irq_status_r;
            OFF_IRQ_MASK:   rd_nxt[ST_W-1:0]          = irq_mask_r;
            OFF_PORT_LEVEL: rd_nxt                    = pin_s2_r;
            default:        rd_nxt = RST_ZERO;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= '0;
        end else begin
            // Ack never stands two cycles in a row
            WB_ACK_O <= bus_req;
            if (rd_en) begin
                WB_DAT_O <= rd_nxt;
            end
        end
    end
endmodule
`default_nettype wire

//--- ksd_pkg.sv
// Package: register map, field layout and shared types of the key scanner
package ksd_pkg;
    localparam int          NUM_SCAN        = 32;
    localparam int          NUM_PEV         = 5;
    localparam int          DEB_W           = 6;
    localparam int          SEL_W           = 5;
    // Timing
    localparam int          CLK_HZ          = 100_000_000;
    localparam int          TICK_MS         = 1;
    localparam int          TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    // Register byte offsets
    localparam logic [7:0]  OFF_SCAN_SETUP  = 8'h00;
    localparam logic [7:0]  OFF_SCAN_EN     = 8'h04;
    localparam logic [7:0]  OFF_DEBOUNCE    = 8'h08;
    localparam logic [7:0]  OFF_PEV_CTRL    = 8'h0C;
    localparam logic [7:0]  OFF_PEV_SEL     = 8'h10;
    localparam logic [7:0]  OFF_PEV_CLEAR   = 8'h14;
    localparam logic [7:0]  OFF_PEV_FLAGS   = 8'h18;
    localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h1C;
    localparam logic [7:0]  OFF_IRQ_MASK    = 8'h20;
    localparam logic [7:0]  OFF_PORT_LEVEL  = 8'h24;
    // Scan setup fields
    localparam int          SS_REPEAT_LSB   = 0;
    localparam int          SS_POL_BIT      = 8;
    localparam int          SS_REL_BIT      = 9;
    // Debounce register fields
    localparam int          DB_VALUE_LSB    = 0;
    localparam int          DB_SCAN_ON_BIT  = 8;
    localparam int          DB_PEV_ON_LSB   = 9;
    // Pin-event control fields
    localparam int          PC_POL_LSB      = 0;
    localparam int          PC_EDGE_LSB     = 8;
    // Status bits: bit 0 keyboard event, bits 1..5 pin events
    localparam int          ST_W            = 1 + NUM_PEV;
    localparam logic [31:0] RST_ZERO        = 32'h0000_0000;

    typedef enum logic [1:0] {KSD_IDLE, KSD_DEBOUNCE, KSD_ACTIVE, KSD_WAIT_REL} ksd_state_t;

    typedef struct packed {
        logic [DEB_W-1:0] debounce_time_ms;
        logic             deb_on;
        logic             polarity;
        logic             edge_mode;
    } ksd_pev_cfg_t;

    // Pick selected input out of the port
    function automatic logic ksd_pick(input logic [NUM_SCAN-1:0] v, input logic [SEL_W-1:0] s);
        ksd_pick = v[s];
    endfunction
endpackage

//--- ksd_tick.sv
// Millisecond tick divider
`timescale 1ns/10ps
`default_nettype none
module ksd_tick #(
    parameter int DIV = ksd_pkg::TICK_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    output logic      tick
);
    localparam int CW = $clog2(DIV);
    logic [CW-1:0] cnt_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else if (cnt_r == CW'(DIV - 1)) begin
            cnt_r <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- ksd_pin_event.sv
// One pin-event generator with its own debounce timer and flag
`timescale 1ns/10ps
`default_nettype none
module ksd_pin_event (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  tick,
    input  wire logic                  level,
    input  wire ksd_pkg::ksd_pev_cfg_t cfg,
    input  wire logic                  clear,
    output logic                       flag,
    output logic                       event_pulse
);
    import ksd_pkg::*;
    ksd_state_t       st_r;
    logic [DEB_W-1:0] tmr_r;
    logic             lvl_d_r;
    logic             act;
    logic             hit;

    // Active means high when polarity is 0
    assign act = level ^ cfg.polarity;
    assign hit = act && !lvl_d_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_d_r <= 1'b1;
        end else begin
            lvl_d_r <= act;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r        <= KSD_IDLE;
            tmr_r       <= '0;
            flag        <= 1'b0;
            event_pulse <= 1'b0;
        end else begin
            event_pulse <= 1'b0;
            case (st_r)
                KSD_IDLE: begin
                    if (hit) begin
                        tmr_r <= cfg.debounce_time_ms;
                        st_r  <= KSD_DEBOUNCE;
                    end
                end
                KSD_DEBOUNCE: begin
                    if (!act) begin
                        st_r <= KSD_IDLE;
                    end else if (!cfg.deb_on || tmr_r == '0) begin
                        flag        <= 1'b1;
                        event_pulse <= 1'b1;
                        st_r        <= KSD_ACTIVE;
                    end else if (tick) begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                end
                KSD_ACTIVE: begin
                    if (clear) begin
                        flag <= 1'b0;
                        st_r <= cfg.edge_mode ? KSD_WAIT_REL : KSD_IDLE;
                    end
                end
                KSD_WAIT_REL: begin
                    if (!act) begin
                        st_r <= KSD_IDLE;
                    end
                end
                default: st_r <= KSD_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- ksd_keys.sv
// Model of the keys and switches on the port pins
`timescale 1ns/10ps
`default_nettype none
module ksd_keys (
    // Clock and commanded key levels
    input  wire logic        clk,
    input  wire logic [31:0] want,
    // Port pins, pulled high while a key is open
    output logic      [31:0] pins
);
    initial pins = 32'hFFFF_FFFF;
    always @(posedge clk) pins <= want;
endmodule
`default_nettype wire

//--- ksd_top_checker.sv
// Port assertions for the key scanner block
`timescale 1ns/10ps
`default_nettype none
module ksd_top_checker #(
    parameter int NUM_INPUTS = 32,
    parameter int TICK_DIV   = ksd_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                        CLOCK,
    input  wire logic                        RESET_N,
    // Wishbone
    input  wire logic                        WB_CYC_I,
    input  wire logic                        WB_STB_I,
    input  wire logic                        WB_WE_I,
    input  wire logic [7:0]                  WB_ADR_I,
    input  wire logic [3:0]                  WB_SEL_I,
    input  wire logic [31:0]                 WB_DAT_I,
    input  wire logic [31:0]                 WB_DAT_O,
    input  wire logic                        WB_ACK_O,
    // Pins and interrupts
    input  wire logic [NUM_INPUTS-1:0]       PORT_IN,
    input  wire logic                        KEYBOARD_INTERRUPT,
    input  wire logic [ksd_pkg::NUM_PEV-1:0] PIN_EVENT_INTERRUPT_N,
    input  wire logic                        IRQ
);
    import ksd_pkg::*;
    logic       req;
    logic [4:0] clr_v;
    logic [3:0] acc_r;
    assign req   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign clr_v = (req && WB_WE_I && WB_ADR_I == OFF_PEV_CLEAR) ? WB_DAT_I[4:0] : 5'h00;
    // Recent status or mask accesses
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            acc_r <= 4'h0;
        end else begin
            acc_r <= {acc_r[2:0], req && (WB_ADR_I == OFF_IRQ_STATUS || WB_ADR_I == OFF_IRQ_MASK)};
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    ack_one_a: assert property (req |=> WB_ACK_O)
        else $error("request not acked after one cycle");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held too long");
    ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I) && $past(WB_STB_I))
        else $error("ack without request");
    unmapped_zero_a: assert property (req && !WB_WE_I && WB_ADR_I > OFF_PORT_LEVEL
        |=> WB_DAT_O == RST_ZERO) else $error("unmapped read not zero");
    flag_read_a: assert property (req && !WB_WE_I && WB_ADR_I == OFF_PEV_FLAGS
        |=> WB_DAT_O == {27'h0, ~PIN_EVENT_INTERRUPT_N}) else $error("flags mismatch");
    kbd_pulse_a: assert property (KEYBOARD_INTERRUPT |=> !KEYBOARD_INTERRUPT)
        else $error("keyboard pulse too long");
    irq_drop_a: assert property ($fell(IRQ) |-> acc_r != 4'h0)
        else $error("irq dropped without status access");
    for (genvar g = 0; g < 5; g++) begin : gen_pev
        pev_hold_a: assert property ($rose(PIN_EVENT_INTERRUPT_N[g]) |->
            $past(clr_v[g], 1) || $past(clr_v[g], 2) || $past(clr_v[g], 3))
            else $error("pin event dropped without clear");
    end
    kbd_seen_c: cover property (KEYBOARD_INTERRUPT);
    pev_seen_c: cover property ($fell(PIN_EVENT_INTERRUPT_N[0]));
    irq_seen_c: cover property ($rose(IRQ));
endmodule
bind ksd_top ksd_top_checker #(.NUM_INPUTS(NUM_INPUTS), .TICK_DIV(TICK_DIV)) ksd_top_checker_i (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .PORT_IN(PORT_IN),
    .KEYBOARD_INTERRUPT(KEYBOARD_INTERRUPT), .PIN_EVENT_INTERRUPT_N(PIN_EVENT_INTERRUPT_N),
    .IRQ(IRQ));
`default_nettype wire

//--- ksd_top_bench.sv
// Self-checking bench for the key scanner block
`timescale 1ns/10ps
`default_nettype none
module ksd_top_bench;
    import ksd_pkg::*;
    localparam int TD = 10;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  sel = 4'h0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] want = 32'hFFFF_FFFF;
    logic [31:0] rdat, pins, q;
    logic        ack, kbd, irq;
    logic [4:0]  pev_n;
    int          n;
    int          fail_count = 0;
    int          checked = 0;
    always #5 clk = ~clk;
    ksd_keys ksd_keys_i (.clk(clk), .want(want), .pins(pins));
    ksd_top #(.TICK_DIV(TD)) ksd_top_i (
        .CLOCK(clk), .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .PORT_IN(pins), .KEYBOARD_INTERRUPT(kbd), .PIN_EVENT_INTERRUPT_N(pev_n), .IRQ(irq));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chkr(input int g, input int lo, input int hi);
        checked++;
        if (g < lo || g > hi) begin
            fail_count++;
            $display("[ERR] %0t delay %0d not in %0d..%0d", $time, g, lo, hi);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        {cyc, stb, we, sel} <= {2'b11, w, 4'hF};
        adr <= a;
        wdat <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'b00;
        chkr(k, 2, 2);
    endtask
    // Cycles until a keyboard pulse or a pin event, 999 if none
    task automatic wt(input int s, input int lim);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((s < 0 ? kbd : !pev_n[s]) !== 1'b1 && n < lim);
        if ((s < 0 ? kbd : !pev_n[s]) !== 1'b1) n = 999;
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 36; a += 4) begin
            bus(1'b0, 8'(a), 32'h0);
            if (a != 20) chk(q, RST_ZERO);
        end
        bus(1'b0, OFF_PORT_LEVEL, 32'h0);
        chk(q, 32'hFFFF_FFFF);
        chk({27'h0, pev_n}, 32'h1F);
        bus(1'b1, OFF_PEV_FLAGS, 32'hFFFF_FFFF);
        bus(1'b1, 8'h2C, 32'hFFFF_FFFF);
        bus(1'b0, OFF_PEV_FLAGS, 32'h0);
        chk(q, RST_ZERO);
        bus(1'b0, 8'h2C, 32'h0);
        chk(q, RST_ZERO);
        $display("test reset done");
        bus(1'b1, OFF_SCAN_EN, 32'h0000_0008);
        bus(1'b1, OFF_IRQ_MASK, 32'h0000_003F);
        want[5] <= 1'b0;
        wt(-1, 30);
        chkr(n, 999, 999);
        want[3] <= 1'b0;
        wt(-1, 30);
        chkr(n, 2, 12);
        wt(-1, 100);
        chkr(n, 999, 999);
        want[3] <= 1'b1;
        wt(-1, 40);
        chkr(n, 999, 999);
        chk({31'h0, irq}, 32'h1);
        bus(1'b0, OFF_IRQ_STATUS, 32'h0);
        chk(q, 32'h1);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        $display("test scan plain done");
        bus(1'b1, OFF_DEBOUNCE, 32'h0000_0103);
        bus(1'b1, OFF_SCAN_SETUP, 32'h0000_0202);
        want[3] <= 1'b0;
        wt(-1, 60);
        chkr(n, 2*TD, 3*TD+12);
        repeat (2) begin
            wt(-1, 60);
            chkr(n, 2*TD-1, 2*TD+1);
        end
        want[3] <= 1'b1;
        wt(-1, 60);
        chkr(n, 2*TD, 3*TD+12);
        want[3] <= 1'b0;
        repeat (8) @(posedge clk);
        want[3] <= 1'b1;
        wt(-1, 60);
        chkr(n, 999, 999);
        bus(1'b1, OFF_DEBOUNCE, 32'h0000_013F);
        bus(1'b1, OFF_SCAN_SETUP, 32'h0);
        want[3] <= 1'b0;
        wt(-1, 700);
        chkr(n, 62*TD, 63*TD+12);
        bus(1'b1, OFF_DEBOUNCE, 32'h0);
        bus(1'b1, OFF_SCAN_SETUP, 32'h0000_0100);
        repeat (5) @(posedge clk);
        want[3] <= 1'b1;
        wt(-1, 30);
        chkr(n, 2, 12);
        bus(1'b0, OFF_IRQ_STATUS, 32'h0);
        $display("test scan debounce done");
        want[14:10] <= 5'h00;
        // Generator i watches pin 10+i
        bus(1'b1, OFF_PEV_SEL, 32'h00E6_B16A);
        bus(1'b1, OFF_PEV_CTRL, 32'h0000_1F00);
        bus(1'b1, OFF_DEBOUNCE, 32'h0000_0403);
        for (int i = 0; i < 5; i++) begin
            want[10+i] <= 1'b1;
            wt(i, 60);
            if (i == 1) chkr(n, 2*TD, 3*TD+12);
            else chkr(n, 2, 12);
            repeat (30) @(posedge clk);
            chk({27'h0, pev_n}, {27'h0, 5'h1F ^ (5'h01 << i)});
            bus(1'b0, OFF_PEV_FLAGS, 32'h0);
            chk(q, 32'h1 << i);
            bus(1'b1, OFF_PEV_CLEAR, 32'h1 << i);
            repeat (4) @(posedge clk);
            chk({27'h0, pev_n}, 32'h1F);
            wt(i, 30);
            chkr(n, 999, 999);
            want[10+i] <= 1'b0;
            repeat (8) @(posedge clk);
        end
        chk({31'h0, irq}, 32'h1);
        bus(1'b0, OFF_IRQ_STATUS, 32'h0);
        chk(q, 32'h0000_003E);
        bus(1'b1, OFF_IRQ_MASK, 32'h0);
        want[10] <= 1'b1;
        wt(0, 30);
        chkr(n, 2, 12);
        bus(1'b1, OFF_PEV_CLEAR, 32'h1);
        bus(1'b1, OFF_PEV_CTRL, 32'h0000_1F01);
        want[10] <= 1'b0;
        wt(0, 30);
        chkr(n, 2, 12);
        chk({31'h0, irq}, 32'h0);
        bus(1'b0, OFF_IRQ_STATUS, 32'h0);
        chk(q, 32'h2);
        // Level mode: clear returns to idle, held input needs a new edge
        bus(1'b1, OFF_PEV_CTRL, 32'h0000_1E01);
        bus(1'b1, OFF_PEV_CLEAR, 32'h1);
        wt(0, 30);
        chkr(n, 999, 999);
        want[10] <= 1'b1;
        repeat (8) @(posedge clk);
        want[10] <= 1'b0;
        wt(0, 30);
        chkr(n, 2, 12);
        $display("test pin events done");
        finish_test();
    end
    initial begin
        #200_000;
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        finish_test();
    end
endmodule
`default_nettype wire
